// ---- hdl/timer_channel.sv ----
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - Mode lower bit picks capture or compare
// - Edge field 00 releases the pin
// - Capture edge: rising, falling or both
// - Compare match: none, toggle, clear, set
// - Mode upper bit gives edge-aligned PWM
// - Center-aligned select forces center PWM
// - Channel value resets to zero
// - Capture read latches both bytes coherently
// - Control write unlatches both latches
// - Value writes ignored in capture mode
// - Debug halt freezes latch, reads live
// - Compare/PWM writes buffered until both bytes
// - Clock off: load on second byte
// - Compare: load at next counter step
// - PWM: load on a step leaving modulo-minus-one, up or down
// - Bytes accepted in either order
// - Debug halt writes go straight active
// - Halt writes keep partial sequence intact
// - Center select applies to all channels
// - Clock source 00 disables counting
// - Flag on capture edge or match
module timer_channel
   import timer_channel_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   // Module-level counter view and debug state
   input wire counter_view_t counter_i,
   input wire logic debug_halt_i,
   // Channel pin
   input wire logic channel_pin_i,
   output logic channel_pin_o,
   output logic channel_pin_oe_o,
   // Status
   output logic channel_event_flag_o,
   output logic [15:0] channel_value_o
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------

   // Center-aligned select wins over the mode bits
   // The edge field sets the pin action and capture edge, not the mode
   function automatic channel_mode_t decode_mode(input logic center, input logic upper, input logic lower);
      if (center) begin
         decode_mode = MODE_CENTER_PWM;
      end else if (upper) begin
         decode_mode = MODE_EDGE_PWM;
      end else if (lower) begin
         decode_mode = MODE_COMPARE;
      end else begin
         decode_mode = MODE_CAPTURE;
      end
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // All state clears on the synchronous reset
   logic [7:0] control; // Control/status byte, flag lives in bit 7
   logic [15:0] active_value; // Value used for compare and PWM
   logic [15:0] write_buffer; // Staged bytes of a coherent write
   logic [15:0] read_buffer; // Snapshot for a coherent read
   logic write_high_done; // High byte staged
   logic write_low_done; // Low byte staged
   logic write_pending; // Both staged, waiting for load point
   logic read_latched; // First half of a coherent read taken
   logic flag_read_armed; // Flag seen set by a control read
   logic pin_out; // Output level driven when owned
   logic [2:0] pin_sync; // Three-stage pin synchroniser
   logic pin_prev; // Last agreed pin level

   // Mode and pin ownership
   channel_mode_t mode;
   logic [1:0] edge_select;
   logic pin_owned;
   logic is_capture;

   // Register port qualifiers
   logic write_ctl;
   logic write_high;
   logic write_low;
   logic read_high;
   logic read_low;

   // Pin edge detection
   logic pin_stable;
   logic pin_rise;
   logic pin_fall;
   logic capture_event;

   // Match and load timing
   logic match;
   logic full_duty;
   logic match_event;
   logic load_point;
   logic clock_on;
   logic [15:0] modulo_top;

   // ---------------------------------------------------------------
   // Combinational decode
   // ---------------------------------------------------------------

   // Index 3 is unmapped: no strobe fires for it
   always_comb begin
      mode = decode_mode(counter_i.center_aligned_select, control[MODE_UPPER_BIT], control[MODE_LOWER_BIT]);
      edge_select = {control[EDGE_UPPER_BIT], control[EDGE_LOWER_BIT]};
      pin_owned = (edge_select != EDGE_NONE);
      is_capture = (mode == MODE_CAPTURE);
      write_ctl = reg_write_i && (reg_addr_i == ADDR_CONTROL_STATUS);
      write_high = reg_write_i && (reg_addr_i == ADDR_VALUE_HIGH);
      write_low = reg_write_i && (reg_addr_i == ADDR_VALUE_LOW);
      read_high = reg_read_i && (reg_addr_i == ADDR_VALUE_HIGH);
      read_low = reg_read_i && (reg_addr_i == ADDR_VALUE_LOW);
      clock_on = (counter_i.clock_source_select != CLOCK_SOURCE_OFF);
      modulo_top = (counter_i.modulo == 16'h0000) ? FREE_RUN_MODULO : counter_i.modulo;
   end

   // Edge detection only looks at agreed stages two and three
   // Edge field 00 disables capture
   always_comb begin
      pin_stable = (pin_sync[1] == pin_sync[2]);
      pin_rise = pin_stable && pin_sync[2] && !pin_prev;
      pin_fall = pin_stable && !pin_sync[2] && pin_prev;
      unique case (edge_select)
         EDGE_RISE: capture_event = pin_rise;
         EDGE_FALL: capture_event = pin_fall;
         EDGE_BOTH: capture_event = pin_rise || pin_fall;
         EDGE_NONE: capture_event = 1'b0;
      endcase
      capture_event = capture_event && is_capture;
   end

   // A step marks the edge at which the count moves,
   // so count is the value being left
   // Match on a counter step; PWM at 0% or 100% raises no flag
   always_comb begin
      match = clock_on && counter_i.count_step && (counter_i.count == active_value);
      full_duty = (active_value == 16'h0000) || (active_value > modulo_top);
      if (mode == MODE_CENTER_PWM) begin
         match = match && counter_i.counting_up;
      end
      match_event = match && !is_capture && !((mode != MODE_COMPARE) && full_duty);
   end

   // Load point for a completed buffered write
   // Modulo minus one with a step moves onto modulo, or down from it in center PWM
   always_comb begin
      if (!clock_on) begin
         load_point = 1'b1;
      end else if (mode == MODE_COMPARE) begin
         load_point = counter_i.count_step;
      end else begin
         load_point = counter_i.count_step && (counter_i.count == modulo_top - 16'h0001);
      end
   end

   // ---------------------------------------------------------------
   // Pin input synchroniser
   // ---------------------------------------------------------------

   // Three stages; a change counts once stages two and three agree
   // Stage one may be metastable; nothing else reads it
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pin_sync <= 3'h0;
         pin_prev <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], channel_pin_i};
         if (pin_stable) begin
            pin_prev <= pin_sync[2]; // Software must hold pin quiet before capture
         end
      end
   end

   // ---------------------------------------------------------------
   // Control/status register and event flag
   // ---------------------------------------------------------------

   // Flag clears by read-then-write-zero; a new event wins over the clear
   // Arming stops a stale read clearing a fresh flag
   // Bit 6 is only stored; no interrupt here
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         control <= CONTROL_RESET;
         flag_read_armed <= 1'b0;
      end else begin
         if (reg_read_i && reg_addr_i == ADDR_CONTROL_STATUS && control[FLAG_BIT]) begin
            flag_read_armed <= 1'b1;
         end
         if (write_ctl) begin
            control[6:0] <= reg_wdata_i[6:0];
            if (!reg_wdata_i[FLAG_BIT] && flag_read_armed) begin
               control[FLAG_BIT] <= 1'b0;
            end
            flag_read_armed <= 1'b0;
         end
         if (capture_event || match_event) begin
            control[FLAG_BIT] <= 1'b1;
            flag_read_armed <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Channel value, write coherency and debug bypass
   // ---------------------------------------------------------------

   // Capture wins, halt stores directly, else bytes
   // are staged and move as one word
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         active_value <= VALUE_RESET;
         write_buffer <= VALUE_RESET;
         write_high_done <= 1'b0;
         write_low_done <= 1'b0;
         write_pending <= 1'b0;
      end else begin
         if (capture_event) begin
            active_value <= counter_i.count;
         end else if (is_capture) begin
            // Bus writes dropped while capturing
         end else if (debug_halt_i) begin
            // Direct store, staged bytes left alone
            if (write_high) begin
               active_value[15:8] <= reg_wdata_i;
            end
            if (write_low) begin
               active_value[7:0] <= reg_wdata_i;
            end
         end else begin
            if (write_high) begin
               write_buffer[15:8] <= reg_wdata_i;
               write_high_done <= 1'b1;
            end
            if (write_low) begin
               write_buffer[7:0] <= reg_wdata_i;
               write_low_done <= 1'b1;
            end
            // A newer pair replaces one still waiting
            if ((write_high && write_low_done) || (write_low && write_high_done)) begin
               write_pending <= 1'b1; // Second byte completes the pair
               write_high_done <= 1'b0;
               write_low_done <= 1'b0;
               if (!clock_on) begin
                  // Clock off: take the pair now, merging the byte in flight
                  active_value <= write_high ? {reg_wdata_i, write_buffer[7:0]} : {write_buffer[15:8], reg_wdata_i};
                  write_pending <= 1'b0;
               end
            end else if (write_pending && load_point) begin
               active_value <= write_buffer;
               write_pending <= 1'b0;
            end
         end
         if (write_ctl) begin
            write_high_done <= 1'b0;
            write_low_done <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read coherency
   // ---------------------------------------------------------------

   // Halt freezes the latch so a half-done read resumes correctly
   // First read of a pair latches, second releases
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         read_latched <= 1'b0;
         read_buffer <= VALUE_RESET;
      end else if (write_ctl) begin
         read_latched <= 1'b0;
      end else if (!debug_halt_i && is_capture && (read_high || read_low)) begin
         if (!read_latched) begin
            read_buffer <= active_value;
            read_latched <= 1'b1;
         end else begin
            read_latched <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register read data, one cycle after the strobe
   // ---------------------------------------------------------------

   // Read data stand one cycle, zero otherwise
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         unique case (reg_addr_i)
            ADDR_CONTROL_STATUS: reg_rdata_o <= control;
            ADDR_VALUE_HIGH: reg_rdata_o <= (read_latched && !debug_halt_i) ? read_buffer[15:8]
                                                                             : active_value[15:8];
            ADDR_VALUE_LOW: reg_rdata_o <= (read_latched && !debug_halt_i) ? read_buffer[7:0]
                                                                           : active_value[7:0];
            default: reg_rdata_o <= 8'h00; // Unmapped index
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Pin output
   // ---------------------------------------------------------------

   // Compare acts per edge field; PWM clears or sets on match
   // Limitation: edge PWM restart needs a step at top,
   // so a frozen counter leaves the pin as it was
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pin_out <= 1'b0;
      end else if (match && pin_owned) begin
         unique case (mode)
            MODE_COMPARE: begin
               if (edge_select == EDGE_RISE) begin
                  pin_out <= !pin_out;
               end else if (edge_select == EDGE_FALL) begin
                  pin_out <= 1'b0;
               end else begin
                  pin_out <= 1'b1;
               end
            end
            MODE_EDGE_PWM, MODE_CENTER_PWM: begin
               pin_out <= control[EDGE_LOWER_BIT]; // X1 sets, 10 clears
            end
            // Capture never drives; level is held
            MODE_CAPTURE: begin
               pin_out <= pin_out;
            end
         endcase
      end else if (pin_owned && !is_capture && (mode != MODE_COMPARE) && counter_i.count_step
                   && counter_i.count == modulo_top && mode == MODE_EDGE_PWM) begin
         pin_out <= !control[EDGE_LOWER_BIT]; // Period restart for edge PWM
      end
   end

   // Registered outputs
   // Value and flag lag their sources by one cycle
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         channel_pin_oe_o <= 1'b0;
         channel_pin_o <= 1'b0;
         channel_event_flag_o <= 1'b0;
         channel_value_o <= VALUE_RESET;
      end else begin
         channel_pin_oe_o <= pin_owned && !is_capture;
         channel_pin_o <= pin_out;
         channel_event_flag_o <= control[FLAG_BIT];
         channel_value_o <= active_value;
      end
   end

endmodule

// ---- hdl/timer_channel_pkg.sv ----
package timer_channel_pkg;

   // ---------------------------------------------------------------
   // Register map (indices on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [1:0] ADDR_CONTROL_STATUS = 2'h0;
   localparam logic [1:0] ADDR_VALUE_HIGH = 2'h1;
   localparam logic [1:0] ADDR_VALUE_LOW = 2'h2;

   // ---------------------------------------------------------------
   // Control/status field positions
   // ---------------------------------------------------------------
   localparam int FLAG_BIT = 7;
   localparam int INT_ENABLE_BIT = 6;
   localparam int MODE_UPPER_BIT = 5;
   localparam int MODE_LOWER_BIT = 4;
   localparam int EDGE_UPPER_BIT = 3;
   localparam int EDGE_LOWER_BIT = 2;

   // ---------------------------------------------------------------
   // Reset values and encodings
   // ---------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] CLOCK_SOURCE_OFF = 2'h0;
   localparam logic [15:0] FREE_RUN_MODULO = 16'hffff;

   // Decoded channel mode
   typedef enum logic [1:0] {
      MODE_CAPTURE,
      MODE_COMPARE,
      MODE_EDGE_PWM,
      MODE_CENTER_PWM
   } channel_mode_t;

   // Counter view supplied by the module-level timer logic
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] modulo;
      logic [1:0] clock_source_select;
      logic center_aligned_select;
      logic count_step;
      logic counting_up;
   } counter_view_t;

endpackage

// ---- tb/timer_counter_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Module-level counter seen by the channel
// ---------------------------------------------------------------
module timer_counter_model
   import timer_channel_pkg::*;
#(
   parameter logic [15:0] MODULO = 16'h0010,
   parameter int STEP_PERIOD = 4
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Bench controls
   input wire logic run_i,
   input wire logic [1:0] clock_source_select_i,
   input wire logic center_i,
   // Counter view
   output counter_view_t counter_o
);
   logic [15:0] count; // Current count
   logic step; // One-cycle advance pulse
   logic up; // Direction in up/down mode
   int unsigned prescale; // Prescaler position

   // Bench may hold run_i low to freeze the count with a source selected
   always_ff @(posedge sys_clk_i) begin
      step <= 1'b0;
      if (reset_i) begin
         prescale <= 0;
         count <= 16'h0000;
         up <= 1'b1;
      end else if (run_i && clock_source_select_i != CLOCK_SOURCE_OFF) begin
         prescale <= (prescale + 1) % STEP_PERIOD;
         if (prescale == STEP_PERIOD - 2) begin
            step <= 1'b1; // Step leads the count move by one edge
         end
         if (prescale == STEP_PERIOD - 1) begin
            if (!center_i) begin
               count <= (count == MODULO) ? 16'h0000 : count + 16'h0001;
            end else if (up) begin
               count <= count + 16'h0001;
               up <= (count + 16'h0001) != MODULO;
            end else begin
               count <= count - 16'h0001;
               up <= (count - 16'h0001) == 16'h0000;
            end
         end
      end
   end

   assign counter_o = '{count, MODULO, clock_source_select_i, center_i, step, up};
endmodule

// ---- tb/timer_channel_chk.sv ----
`timescale 1ns/10ps
module timer_channel_chk
   import timer_channel_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [7:0] reg_rdata_o,
   // Counter, debug, pin and status
   input wire counter_view_t counter_i,
   input wire logic debug_halt_i,
   input wire logic channel_pin_i,
   input wire logic channel_pin_o,
   input wire logic channel_pin_oe_o,
   input wire logic channel_event_flag_o,
   input wire logic [15:0] channel_value_o
);
   logic [3:0] mode_edge; // Shadow of mode and edge bits
   logic capture_mode; // Decoded capture mode
   logic drive_expected; // Pin should be driven
   logic [7:0] value_high; // Upper half of value output

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // Shadow follows control writes only
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mode_edge <= 4'h0;
      end else if (reg_write_i && reg_addr_i == ADDR_CONTROL_STATUS) begin
         mode_edge <= reg_wdata_i[MODE_UPPER_BIT:EDGE_LOWER_BIT];
      end
   end

   // Center select wins over the mode bits
   assign capture_mode = !counter_i.center_aligned_select && mode_edge[3:2] == 2'h0;
   assign drive_expected = mode_edge[1:0] != EDGE_NONE && !capture_mode;
   assign value_high = channel_value_o[15:8];

   a_pin_released: assert property (
      $past(mode_edge[1:0] == EDGE_NONE) |-> !channel_pin_oe_o) else $error("pin driven with edge field clear");
   a_capture_no_drive: assert property (
      $past(capture_mode) |-> !channel_pin_oe_o) else $error("pin driven in capture mode");
   a_mode_drives_pin: assert property (
      $past(drive_expected) |-> channel_pin_oe_o) else $error("pin not driven in output mode");
   a_value_reset_clear: assert property (
      $fell(reset_i) |-> channel_value_o == VALUE_RESET) else $error("value not clear after reset");
   a_capture_write_drop: assert property (
      reg_write_i && reg_addr_i != ADDR_CONTROL_STATUS && capture_mode && $stable(channel_pin_i)
      |=> $stable(channel_value_o) [*3]) else $error("value write took effect in capture mode");
   a_halt_write_direct: assert property (
      debug_halt_i && reg_write_i && reg_addr_i == ADDR_VALUE_HIGH && !capture_mode
      |-> ##2 channel_value_o[15:8] == $past(reg_wdata_i, 2)) else $error("halt write not direct");
   a_halt_read_live: assert property (
      debug_halt_i && reg_read_i && reg_addr_i == ADDR_VALUE_HIGH && !$past(reg_write_i)
      |=> reg_rdata_o == $past(value_high)) else $error("halt read not live");
   a_ctrl_readback: assert property (
      reg_read_i && reg_addr_i == ADDR_CONTROL_STATUS |=> reg_rdata_o[5:2] == $past(mode_edge))
      else $error("control bits read back wrong");

   c_capture_read: cover property (capture_mode && reg_read_i && reg_addr_i == ADDR_VALUE_HIGH);
   c_halt_write: cover property (debug_halt_i && reg_write_i && reg_addr_i == ADDR_VALUE_HIGH);
   c_pwm_drive: cover property (drive_expected && mode_edge[3]);
endmodule

bind timer_channel timer_channel_chk chk_u (.sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
   .reg_read_i, .reg_rdata_o, .counter_i, .debug_halt_i, .channel_pin_i, .channel_pin_o, .channel_pin_oe_o,
   .channel_event_flag_o, .channel_value_o);

// ---- tb/test_timer_channel.sv ----
`timescale 1ns/10ps
module test_timer_channel
   import timer_channel_pkg::*;
;
   logic sys_clk_i, reset_i, reg_write_i, reg_read_i, debug_halt_i, channel_pin_i;
   logic [1:0] reg_addr_i, source;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   logic channel_pin_o, channel_pin_oe_o, channel_event_flag_o, run, center;
   logic [15:0] channel_value_o;
   counter_view_t counter_i;
   int err_count, checks;

   timer_counter_model counter_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .run_i(run),
      .clock_source_select_i(source), .center_i(center), .counter_o(counter_i));
   timer_channel dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
      .counter_i(counter_i), .debug_halt_i(debug_halt_i), .channel_pin_i(channel_pin_i),
      .channel_pin_o(channel_pin_o), .channel_pin_oe_o(channel_pin_oe_o),
      .channel_event_flag_o(channel_event_flag_o), .channel_value_o(channel_value_o));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      checks++;
      if (seen !== expected) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // One-cycle strobes; a free cycle follows each access
   task automatic wr(input logic [1:0] addr, input logic [7:0] data);
      @(posedge sys_clk_i);
      reg_addr_i <= addr;
      reg_wdata_i <= data;
      reg_write_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] addr, output logic [7:0] data);
      @(posedge sys_clk_i);
      reg_addr_i <= addr;
      reg_read_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_read_i <= 1'b0;
      #1;
      data = reg_rdata_o;
   endtask
   task automatic wait_value(input logic [15:0] expected, input bit on_count = 1'b0);
      int n;
      n = 0;
      while ((on_count ? counter_i.count : channel_value_o) !== expected && n < 400) begin
         idle(1);
         n++;
      end
      if (n == 400) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   // Pin edges always land on a clock edge, long after the last mode change
   task automatic pin_to(input logic level);
      @(posedge sys_clk_i);
      channel_pin_i <= level;
      idle(12);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic s_reset();
      logic [7:0] b;
      rd(ADDR_VALUE_HIGH, b);
      check({b, 8'h00}, 16'h0000);
      check(channel_value_o, VALUE_RESET);
   endtask
   task automatic s_write_order();
      wr(ADDR_CONTROL_STATUS, 8'h14);
      wr(ADDR_VALUE_LOW, 8'h34);
      idle(3);
      check(channel_value_o, 16'h0000);
      wr(ADDR_VALUE_HIGH, 8'h12);
      idle(2);
      check(channel_value_o, 16'h1234);
      wr(ADDR_VALUE_HIGH, 8'hab);
      wr(ADDR_VALUE_LOW, 8'hcd);
      idle(2);
      check(channel_value_o, 16'habcd);
   endtask
   task automatic s_unlatch();
      wr(ADDR_VALUE_LOW, 8'h33);
      wr(ADDR_CONTROL_STATUS, 8'h14);
      wr(ADDR_VALUE_HIGH, 8'h44);
      idle(2);
      check(channel_value_o, 16'habcd);
      wr(ADDR_VALUE_LOW, 8'h55);
      idle(2);
      check(channel_value_o, 16'h4455);
   endtask
   task automatic s_halt();
      logic [7:0] b;
      wr(ADDR_VALUE_LOW, 8'h11);
      debug_halt_i <= 1'b1;
      wr(ADDR_VALUE_HIGH, 8'h99);
      idle(2);
      check(channel_value_o, 16'h9955);
      rd(ADDR_VALUE_LOW, b);
      check({8'h00, b}, 16'h0055);
      rd(ADDR_VALUE_HIGH, b);
      check({8'h00, b}, 16'h0099);
      @(posedge sys_clk_i);
      debug_halt_i <= 1'b0;
      wr(ADDR_VALUE_HIGH, 8'h22);
      idle(2);
      check(channel_value_o, 16'h2211);
   endtask
   // Source selected but counter frozen: the pair must wait for a step
   task automatic s_compare_clocked();
      @(posedge sys_clk_i);
      source <= 2'h1;
      wr(ADDR_VALUE_HIGH, 8'h56);
      wr(ADDR_VALUE_LOW, 8'h78);
      idle(6);
      check(channel_value_o, 16'h2211);
      @(posedge sys_clk_i);
      run <= 1'b1;
      wait_value(16'h5678);
   endtask
   task automatic s_pwm();
      wr(ADDR_CONTROL_STATUS, 8'h28);
      wr(ADDR_VALUE_HIGH, 8'h00);
      wr(ADDR_VALUE_LOW, 8'h07);
      wait_value(16'h0007);
      check(counter_i.count, 16'h0010);
      wait_value(16'h0003, 1'b1);
      check({14'h0000, channel_pin_o, channel_event_flag_o}, 16'h0002);
      wait_value(16'h000a, 1'b1);
      check({14'h0000, channel_pin_o, channel_event_flag_o}, 16'h0001);
      check({15'h0000, channel_pin_oe_o}, 16'h0001);
      @(posedge sys_clk_i);
      center <= 1'b1;
      wr(ADDR_CONTROL_STATUS, 8'h08);
      idle(3);
      check({15'h0000, channel_pin_oe_o}, 16'h0001);
      wr(ADDR_CONTROL_STATUS, 8'h18);
      wr(ADDR_CONTROL_STATUS, 8'h00);
      idle(3);
      check({15'h0000, channel_pin_oe_o}, 16'h0000);
      @(posedge sys_clk_i);
      center <= 1'b0;
   endtask
   task automatic s_capture();
      logic [15:0] v;
      logic [7:0] b;
      for (int code = 1; code < 4; code++) begin
         wr(ADDR_CONTROL_STATUS, {4'h0, code[1:0], 2'h0});
         idle(8); // Pin held quiet before edges
         v = channel_value_o;
         pin_to(1'b1);
         check({15'h0000, channel_value_o !== v}, {15'h0000, code[0]});
         v = channel_value_o;
         pin_to(1'b0);
         check({15'h0000, channel_value_o !== v}, {15'h0000, code[1]});
      end
      v = channel_value_o;
      rd(ADDR_VALUE_HIGH, b);
      check({8'h00, b}, {8'h00, v[15:8]});
      pin_to(1'b1);
      rd(ADDR_VALUE_LOW, b);
      check({8'h00, b}, {8'h00, v[7:0]});
      v = channel_value_o;
      wr(ADDR_VALUE_LOW, 8'hee);
      wr(ADDR_VALUE_HIGH, 8'hff);
      idle(3);
      check(channel_value_o, v);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      {reset_i, reg_write_i, reg_read_i, debug_halt_i, channel_pin_i} = 5'h10;
      {reg_addr_i, source, reg_wdata_i, run, center} = 14'h0000;
      err_count = 0;
      checks = 0;
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      s_reset();
      s_write_order();
      s_unlatch();
      s_halt();
      s_compare_clocked();
      s_pwm();
      s_capture();
      tally_and_finish();
   end
endmodule
